// ===== cmpi_pkg.sv
// Constants and types shared by the core memory protect interlock.
package cmpi_pkg;

  // ********************************************************************
  // Clock and timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int DISABLE_DELAY_US = 3;
  localparam int PULSE_GAP_NS = 120;

  // Least times round up to whole cycles, never below one.
  localparam int DISABLE_DELAY_CYC_I =
    (DISABLE_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_GAP_CYC_I = (PULSE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int DLY_W = 6;
  localparam int GAP_W = 3;
  localparam logic [DLY_W-1:0] DISABLE_DELAY_CYC =
    DLY_W'((DISABLE_DELAY_CYC_I < 1) ? 1 : DISABLE_DELAY_CYC_I);
  localparam logic [GAP_W-1:0] PULSE_GAP_CYC =
    GAP_W'((PULSE_GAP_CYC_I < 1) ? 1 : PULSE_GAP_CYC_I);

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [DLY_W-1:0] DLY_CNT_RST = 6'h00;
  localparam logic [GAP_W-1:0] GAP_CNT_RST = 3'h0;
  localparam logic FLAG_RST = 1'b0;

  // ********************************************************************
  // Pulse pair guard states
  // ********************************************************************
  typedef enum logic [1:0] {
    CMPI_IDLE,
    CMPI_POS,
    CMPI_NEG,
    CMPI_GAP
  } cmpi_guard_state_t;

endpackage

// ===== cmpi_pair_if.sv
// Carrier for one guarded pair of voltage switch timing pulses.
`timescale 1ns/1ps
interface cmpi_pair_if;
  logic req_pos;
  logic req_neg;
  logic pulse_pos;
  logic pulse_neg;

  modport guard (
    input req_pos,
    input req_neg,
    output pulse_pos,
    output pulse_neg
  );

  modport user (
    output req_pos,
    output req_neg,
    input pulse_pos,
    input pulse_neg
  );
endinterface

// ===== cmpi_pair_guard.sv
// Overlap guard for one pair of voltage switch timing pulses.
`timescale 1ns/1ps
module cmpi_pair_guard (
  input wire logic clk_sys,
  input wire logic rstn,
  cmpi_pair_if.guard pair
);
  import cmpi_pkg::*;

  cmpi_guard_state_t state_reg;
  cmpi_guard_state_t state_next;
  logic [GAP_W-1:0] gap_reg;
  logic [GAP_W-1:0] gap_next;
  logic pos_reg;
  logic neg_reg;

  // ********************************************************************
  // Next state
  // ********************************************************************
  // A trailing edge always passes through the gap state, so the other pulse
  // of the pair cannot start until the gap has run out.
  always_comb begin
    state_next = state_reg;
    gap_next = gap_reg;
    case (state_reg)
      CMPI_IDLE: begin
        if (pair.req_pos) begin
          state_next = CMPI_POS;
        end else if (pair.req_neg) begin
          state_next = CMPI_NEG;
        end
      end
      CMPI_POS: begin
        if (!pair.req_pos) begin
          state_next = CMPI_GAP;
          gap_next = PULSE_GAP_CYC - 3'h1;
        end
      end
      CMPI_NEG: begin
        if (!pair.req_neg) begin
          state_next = CMPI_GAP;
          gap_next = PULSE_GAP_CYC - 3'h1;
        end
      end
      CMPI_GAP: begin
        if (gap_reg == 3'h0) begin
          state_next = CMPI_IDLE;
        end else begin
          gap_next = gap_reg - 3'h1;
        end
      end
      default: begin
        state_next = CMPI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg <= CMPI_IDLE;
      gap_reg <= GAP_CNT_RST;
      pos_reg <= FLAG_RST;
      neg_reg <= FLAG_RST;
    end else begin
      state_reg <= state_next;
      gap_reg <= gap_next;
      pos_reg <= (state_next == CMPI_POS);
      neg_reg <= (state_next == CMPI_NEG);
    end
  end

  assign pair.pulse_pos = pos_reg;
  assign pair.pulse_neg = neg_reg;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_PAIR_NO_OVERLAP: assert property (!(pos_reg && neg_reg))
    else $error("Both pulses of a pair are active together.");
  AST_PAIR_GAP_AFTER_POS: assert property ($fell(pos_reg) |-> !neg_reg [*2])
    else $error("Negative pulse started inside the gap after a positive pulse.");
  AST_PAIR_GAP_AFTER_NEG: assert property ($fell(neg_reg) |-> !pos_reg [*2])
    else $error("Positive pulse started inside the gap after a negative pulse.");
  AST_PAIR_FOLLOWS_REQ: assert property (!pair.req_pos && !pair.req_neg |=> !pos_reg && !neg_reg)
    else $error("Pulse active without a request.");

  COV_PAIR_POS_THEN_NEG: cover property ($fell(pos_reg) ##[1:6] $rose(neg_reg));
  COV_PAIR_NEG_THEN_POS: cover property ($fell(neg_reg) ##[1:6] $rose(pos_reg));
endmodule

// ===== cmpi_core_memory_protect_interlock.sv
// Top of the core memory protect interlock: predrive disable, monitors, pulse guards.
`timescale 1ns/1ps
// Behaviour
// - While disabled, X and Y predrive outputs are forced to the non-driving level.
// - Disable asserts only after a trigger has stood for three microseconds.
// - Triggers are transition hold, airflow shutdown request, or undervoltage failure.
// - Airflow shutdown request is low normally, high on airflow failure.
// - Transition hold clamps the airflow shutdown request low.
// - Undervoltage failure rises when any monitored rail falls beyond its limit.
// - Undervoltage failure feeds the disable and raises memory fault status.
// - Memory fault status is airflow failure OR undervoltage failure.
// - X and Y pulse pairs are guarded separately; pulses of a pair never overlap.
// - Next pulse of a pair starts at least 120 ns after previous trailing edge.
module cmpi_core_memory_protect_interlock (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic power_transition_hold,
  input wire logic airflow_fail_detect,
  input wire logic rail_p8v_below_limit,
  input wire logic rail_p4v_below_limit,
  input wire logic rail_n8v_above_limit,
  input wire logic rail_p24v_below_limit,
  input wire logic x_predrive_req,
  input wire logic y_predrive_req,
  input wire logic x_switch_pulse_pos_req,
  input wire logic x_switch_pulse_neg_req,
  input wire logic y_switch_pulse_pos_req,
  input wire logic y_switch_pulse_neg_req,
  output logic x_predrive,
  output logic y_predrive,
  output logic predrive_disable,
  output logic airflow_shutdown_request,
  output logic undervoltage_fail,
  output logic memory_fault_status,
  output logic x_switch_pulse_pos,
  output logic x_switch_pulse_neg,
  output logic y_switch_pulse_pos,
  output logic y_switch_pulse_neg
);
  import cmpi_pkg::*;

  // ********************************************************************
  // Monitors
  // ********************************************************************
  wire logic rail_any_fail;
  wire logic airflow_req_next;
  wire logic trigger_any;
  logic airflow_req_reg;
  logic undervolt_reg;
  logic fault_reg;

  assign rail_any_fail = rail_p8v_below_limit | rail_p4v_below_limit
    | rail_n8v_above_limit | rail_p24v_below_limit;
  // The clamp keeps an airflow failure seen during power transitions from tripping the supply.
  assign airflow_req_next = airflow_fail_detect & ~power_transition_hold;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      airflow_req_reg <= FLAG_RST;
      undervolt_reg <= FLAG_RST;
      fault_reg <= FLAG_RST;
    end else begin
      airflow_req_reg <= airflow_req_next;
      undervolt_reg <= rail_any_fail;
      // Raw airflow detector, not the clamped request, so status still reports
      // an airflow failure seen during a transition. It may chatter while the
      // analog detectors settle; consumers must wait for it to stand still.
      fault_reg <= airflow_fail_detect | rail_any_fail;
    end
  end

  assign airflow_shutdown_request = airflow_req_reg;
  assign undervoltage_fail = undervolt_reg;
  assign memory_fault_status = fault_reg;

  // ********************************************************************
  // Predrive disable
  // ********************************************************************
  logic [DLY_W-1:0] dly_reg;
  logic [DLY_W-1:0] dly_next;
  logic disable_reg;
  wire logic dly_done;

  assign trigger_any = power_transition_hold | airflow_req_reg | undervolt_reg;
  assign dly_done = (dly_reg == DISABLE_DELAY_CYC - 6'h01);

  // The counter saturates one short of the delay; the disable flop adds the last cycle.
  always_comb begin
    if (!trigger_any) begin
      dly_next = DLY_CNT_RST;
    end else if (dly_done) begin
      dly_next = dly_reg;
    end else begin
      dly_next = dly_reg + 6'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dly_reg <= DLY_CNT_RST;
      disable_reg <= FLAG_RST;
    end else begin
      dly_reg <= dly_next;
      disable_reg <= trigger_any & dly_done;
    end
  end

  assign predrive_disable = disable_reg;
  assign x_predrive = x_predrive_req & ~disable_reg;
  assign y_predrive = y_predrive_req & ~disable_reg;

  // ********************************************************************
  // Timing pulse guards
  // ********************************************************************
  cmpi_pair_if x_pair ();
  cmpi_pair_if y_pair ();

  assign x_pair.req_pos = x_switch_pulse_pos_req;
  assign x_pair.req_neg = x_switch_pulse_neg_req;
  assign y_pair.req_pos = y_switch_pulse_pos_req;
  assign y_pair.req_neg = y_switch_pulse_neg_req;

  cmpi_pair_guard u_x_guard (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pair(x_pair.guard)
  );

  cmpi_pair_guard u_y_guard (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pair(y_pair.guard)
  );

  assign x_switch_pulse_pos = x_pair.pulse_pos;
  assign x_switch_pulse_neg = x_pair.pulse_neg;
  assign y_switch_pulse_pos = y_pair.pulse_pos;
  assign y_switch_pulse_neg = y_pair.pulse_neg;

  // ********************************************************************
  // Checks
  // ********************************************************************
  logic [7:0] trig_run;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      trig_run <= 8'h00;
    end else if (!trigger_any) begin
      trig_run <= 8'h00;
    end else if (trig_run != 8'hff) begin
      trig_run <= trig_run + 8'h01;
    end
  end

  // ********************************************************************
  // Pair gap watch
  // ********************************************************************
  // Idle cycles since either pulse of a pair was last high. The count rests at
  // full after reset so the first pulse is not taken for one inside a gap.
  localparam logic [2:0] QUIET_FULL = 3'h7;
  logic [2:0] x_quiet;
  logic [2:0] y_quiet;

  function automatic logic [2:0] quiet_step(input logic busy, input logic [2:0] cnt);
    if (busy) begin
      return 3'h0;
    end
    return (cnt == QUIET_FULL) ? cnt : cnt + 3'h1;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      x_quiet <= QUIET_FULL;
    end else begin
      x_quiet <= quiet_step(x_switch_pulse_pos | x_switch_pulse_neg, x_quiet);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      y_quiet <= QUIET_FULL;
    end else begin
      y_quiet <= quiet_step(y_switch_pulse_pos | y_switch_pulse_neg, y_quiet);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_PREDRIVE_BLOCKED: assert property (predrive_disable |-> !x_predrive && !y_predrive)
    else $error("Predrive driven while disabled.");
  AST_PREDRIVE_PASS: assert property (!predrive_disable |-> x_predrive == x_predrive_req
    && y_predrive == y_predrive_req)
    else $error("Predrive request not passed while enabled.");
  AST_DISABLE_NOT_EARLY: assert property (predrive_disable |->
    trig_run >= {2'h0, DISABLE_DELAY_CYC})
    else $error("Predrive disable asserted before three microseconds.");
  AST_DISABLE_ON_TIME: assert property (trig_run == {2'h0, DISABLE_DELAY_CYC} - 8'h01
    && trigger_any |=> predrive_disable)
    else $error("Predrive disable late after three microseconds.");
  AST_DISABLE_STAYS: assert property (predrive_disable && trigger_any
    |=> predrive_disable)
    else $error("Predrive disable dropped while a trigger stands.");
  AST_DISABLE_NEEDS_TRIGGER: assert property (!trigger_any |=> !predrive_disable)
    else $error("Predrive disable without a trigger.");
  AST_AIRFLOW_REQ: assert property (airflow_fail_detect && !power_transition_hold
    |=> airflow_shutdown_request)
    else $error("Airflow failure did not request shutdown.");
  AST_AIRFLOW_QUIET: assert property (!airflow_fail_detect |=> !airflow_shutdown_request)
    else $error("Shutdown request without an airflow failure.");
  AST_AIRFLOW_CLAMP: assert property (power_transition_hold |=> !airflow_shutdown_request)
    else $error("Shutdown request not clamped during power transition.");
  AST_UNDERVOLT: assert property (rail_any_fail |=> undervoltage_fail)
    else $error("Rail below limit did not raise undervoltage failure.");
  AST_UV_QUIET: assert property (!rail_any_fail |=> !undervoltage_fail)
    else $error("Undervoltage failure without a rail beyond its limit.");
  AST_UV_TO_STATUS: assert property (undervoltage_fail |-> memory_fault_status)
    else $error("Undervoltage failure without memory fault status.");
  AST_STATUS_OR: assert property ($past(rstn) |-> memory_fault_status
    == ($past(airflow_fail_detect) || $past(rail_any_fail)))
    else $error("Memory fault status is not the OR of the failures.");
  AST_STATUS_AIRFLOW: assert property (airflow_fail_detect |=> memory_fault_status)
    else $error("Airflow failure did not raise memory fault status.");
  AST_X_PAIR_GAP: assert property ($rose(x_switch_pulse_pos) || $rose(x_switch_pulse_neg)
    |-> x_quiet >= PULSE_GAP_CYC)
    else $error("X pair pulse started inside the gap.");
  AST_Y_PAIR_GAP: assert property ($rose(y_switch_pulse_pos) || $rose(y_switch_pulse_neg)
    |-> y_quiet >= PULSE_GAP_CYC)
    else $error("Y pair pulse started inside the gap.");

  COV_UV_DISABLE: cover property ($rose(undervoltage_fail) ##31 predrive_disable);
  COV_HOLD_CLAMP: cover property (power_transition_hold && airflow_fail_detect);
  COV_SHORT_GLITCH: cover property ($rose(trigger_any) ##5 !trigger_any);
endmodule

// ===== cmpi_far_side.sv
// Far side model: driveline switch pairs and a memory fault status observer.
`timescale 1ns/1ps
module cmpi_far_side (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic memory_fault_status,
  input wire logic x_pos,
  input wire logic x_neg,
  input wire logic y_pos,
  input wire logic y_neg,
  output logic overlap_seen,
  output logic status_settled
);
  logic status_prev;
  // A pair driven both ways at once would short the driveline, so it is latched.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      overlap_seen <= 1'b0;
    end else if ((x_pos && x_neg) || (y_pos && y_neg)) begin
      overlap_seen <= 1'b1;
    end
  end
  // The status may wobble while a fault is judged, so only a repeated value counts.
  always_ff @(posedge clk_sys) begin
    status_prev <= memory_fault_status;
    if (!rstn) begin
      status_settled <= 1'b0;
    end else if (status_prev == memory_fault_status) begin
      status_settled <= memory_fault_status;
    end
  end
endmodule

// ===== cmpi_core_memory_protect_interlock_tb.sv
// Self-checking testbench of the core memory protect interlock.
`timescale 1ns/1ps
module cmpi_core_memory_protect_interlock_tb;
  import cmpi_pkg::*;
  typedef struct {int due; logic [9:0] v;} cmpi_note_t;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic hold = 1'b0;
  logic air = 1'b0;
  logic [3:0] rail = 4'h0;
  logic [1:0] pre = 2'h0;
  logic [3:0] preq = 4'h0;
  wire [9:0] got;
  logic overlap_seen;
  logic status_settled;
  cmpi_note_t q[$];
  int cyc = 0;
  int errors = 0;
  int n_checks = 0;
  int k;
  logic [7:0] lfsr = 8'h33;
  logic m_uv = 1'b0;
  logic m_af = 1'b0;
  logic m_ms = 1'b0;
  logic m_dis = 1'b0;
  int m_cnt = 0;
  int st[2];
  int gc[2];
  logic [1:0] m_p[2];

  cmpi_core_memory_protect_interlock u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .power_transition_hold(hold),
    .airflow_fail_detect(air), .rail_p8v_below_limit(rail[0]),
    .rail_p4v_below_limit(rail[1]), .rail_n8v_above_limit(rail[2]),
    .rail_p24v_below_limit(rail[3]), .x_predrive_req(pre[1]), .y_predrive_req(pre[0]),
    .x_switch_pulse_pos_req(preq[3]), .x_switch_pulse_neg_req(preq[2]),
    .y_switch_pulse_pos_req(preq[1]), .y_switch_pulse_neg_req(preq[0]),
    .x_predrive(got[9]), .y_predrive(got[8]), .predrive_disable(got[7]),
    .airflow_shutdown_request(got[6]), .undervoltage_fail(got[5]),
    .memory_fault_status(got[4]), .x_switch_pulse_pos(got[3]),
    .x_switch_pulse_neg(got[2]), .y_switch_pulse_pos(got[1]), .y_switch_pulse_neg(got[0])
  );
  cmpi_far_side u_far (
    .clk_sys(clk_sys), .rstn(rstn), .memory_fault_status(got[4]), .x_pos(got[3]),
    .x_neg(got[2]), .y_pos(got[1]), .y_neg(got[0]), .overlap_seen(overlap_seen),
    .status_settled(status_settled)
  );

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  // ********************************************************************
  // Reference model and checks
  // ********************************************************************
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic guard(input int i, input logic p, input logic n);
    case (st[i])
      0: begin
        st[i] = p ? 1 : (n ? 2 : 0);
      end
      1, 2: begin
        if (!(st[i] == 1 ? p : n)) begin
          st[i] = 3;
          gc[i] = PULSE_GAP_CYC;
        end
      end
      default: begin
        gc[i]--;
        if (gc[i] == 0) begin
          st[i] = 0;
        end
      end
    endcase
    m_p[i] = {st[i] == 1, st[i] == 2};
  endtask

  // Drives one cycle at the falling edge and notes what the next rising edge must give.
  task automatic step(input logic r, input logic h, input logic a, input logic [3:0] rl,
                      input logic [3:0] pr);
    logic trig;
    @(negedge clk_sys);
    lfsr = lfsr_next(lfsr);
    rstn = r;
    hold = h;
    air = a;
    rail = rl;
    preq = pr;
    pre = lfsr[1:0];
    trig = h | m_af | m_uv;
    if (!r) begin
      {m_uv, m_af, m_ms, m_dis} = 4'h0;
      m_cnt = 0;
      st = '{0, 0};
      m_p = '{2'h0, 2'h0};
    end else begin
      m_dis = trig && (m_cnt >= int'(DISABLE_DELAY_CYC) - 1);
      m_cnt = trig ? m_cnt + 1 : 0;
      m_uv = |rl;
      m_af = a & ~h;
      m_ms = a | (|rl);
      guard(0, pr[3], pr[2]);
      guard(1, pr[1], pr[0]);
    end
    q.push_back('{cyc + 1, {pre & ~{2{m_dis}}, m_dis, m_af, m_uv, m_ms, m_p[0], m_p[1]}});
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    #1;
    while (q.size() > 0 && q[0].due == cyc) begin
      check(got[9:8], q[0].v[9:8]);
      check(got[7], q[0].v[7]);
      check(got[6], q[0].v[6]);
      check(got[5:4], q[0].v[5:4]);
      check(got[3:0], q[0].v[3:0]);
      void'(q.pop_front());
    end
    if (cyc == 3000) begin
      errors++;
      end_sim();
    end
  end

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  initial begin
    repeat (4) step(0, 0, 0, 4'h0, 4'h0);
    step(1, 0, 0, 4'h0, 4'h0);
    repeat (400) step(1, &lfsr[7:5], &lfsr[4:2], (lfsr[7:6] == 2'h3) ? lfsr[3:0] : 4'h0,
                      lfsr[7:4]);
    $display("test random done");
    // Hold, airflow, each rail, a trigger one cycle short, then hold with airflow.
    for (k = 0; k < 8; k++) begin
      repeat (k == 6 ? 29 : 35) step(1, k == 0 || k >= 6, k == 1 || k == 7,
                                     (k >= 2 && k <= 5) ? 4'h1 << (k - 2) : 4'h0, lfsr[7:4]);
      check(status_settled, (k >= 1 && k <= 5) || k == 7);
      repeat (3) step(1, 0, 0, 4'h0, 4'h0);
    end
    $display("test triggers done");
    repeat (2) step(0, 1, 1, 4'hf, 4'hf);
    step(1, 0, 0, 4'h0, 4'h0);
    repeat (50) step(1, 0, 0, 4'h0, lfsr[7:4]);
    check(overlap_seen, 1'b0);
    $display("test reset done");
    repeat (2) @(posedge clk_sys);
    end_sim();
  end
endmodule
